// >>> core/uqc_irq_ctrl.sv
// Contract
// (R1) Rx data interrupt follows trigger level
// (R2) Data ready set on load, cleared empty
// (R3) All basic masks off gives polled mode
// (R4) Line status bits one to seven mapped
// (R5) Mask bit zero enables rx data
// (R6) Mask bit one enables tx ready
// (R7) Overrun immediate, errors at read port
// (R8) Modem deltas interrupt, cleared by read
// (R9) Upper mask bits need enhanced enable
// (R10) Rising flow pins raise interrupt
// (R11) Timeout after four chars twelve bits
// (R12) Tx ready cleared by source read/write
// (R13) Line read clears, global error persists
// (R14) Xoff and special clearing conditions
// (R15) Wake-up interrupt reports bit zero set
// (R16) Only highest pending source reported
// (R17) Six bit source codes by priority
// (R18) Bit zero low while pending
// (R19) Bits seven six show queue enable
// (R20) Bits five four need enhanced enable
// (R21) Enable bit gates other control bits
// (R22) Rx queue reset self-clearing pulse
// (R23) Tx queue reset self-clearing pulse
// (R24) Trigger select 1, 4, 8, 14
// (R25) Interrupt output while enabled pending
`timescale 1ns/1ps
module uqc_irq_ctrl
  import uqc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire uqc_bus_s bus,
  output logic [7:0] rd_data,
  input wire logic enh_enable,
  input wire uqc_rx_s rx,
  input wire uqc_tx_s tx,
  input wire uqc_flow_s flow,
  input wire logic cts_n_pin,
  input wire logic bit_tick,
  input wire logic [3:0] char_bits,
  output logic irq,
  output logic fifo_enable,
  output logic rx_fifo_reset,
  output logic tx_fifo_reset,
  output logic [4:0] rx_trigger,
  output logic [4:0] tx_trigger,
  output logic sleep_enable
);
  // Control registers
  logic [7:0] mask;
  logic fifo_en;
  logic [1:0] rx_sel;
  logic [1:0] tx_sel;
  logic rx_rst;
  logic tx_rst;
  logic [7:0] next_mask;
  logic next_fifo_en;
  logic [1:0] next_rx_sel;
  logic [1:0] next_tx_sel;
  logic next_rx_rst;
  logic next_tx_rst;
  // Sticky pending flags
  logic line_pend;
  logic overrun;
  logic tmo_pend;
  logic tx_pend;
  logic modem_pend;
  logic pin_pend;
  logic xoff_pend;
  logic spec_pend;
  logic wake_pend;
  logic tx_below_q;
  logic next_line_pend;
  logic next_overrun;
  logic next_tmo_pend;
  logic next_tx_pend;
  logic next_modem_pend;
  logic next_pin_pend;
  logic next_xoff_pend;
  logic next_spec_pend;
  logic next_wake_pend;
  logic next_tx_below_q;
  logic rts_q;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  // Decoded strobes and derived terms
  logic rd_rx_hold, wr_tx_hold, wr_mask, rd_mask, rd_source, wr_qc, rd_line, rd_modem;
  logic [7:0] eff_mask;
  logic rx_data_act;
  logic tx_below;
  logic cts_rise;
  logic rts_rise;
  logic tmo_expire;
  logic [5:0] src_code;
  logic [7:0] source_val;
  logic [7:0] line_val;

  uqc_pin_sync u_cts_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin(cts_n_pin),
    .level(),
    .rise(cts_rise)
  );

  // (R11) Idle timer only runs with data waiting
  uqc_rx_timeout u_timeout (
    .sys_clk(sys_clk),
    .reset(reset),
    .bit_tick(bit_tick),
    .restart(rx.loaded | rd_rx_hold),
    .armed(rx.level != 5'h00),
    .char_bits(char_bits),
    .expire(tmo_expire)
  );

  // Address decode; bank selects follow the line format state
  always_comb begin
    rd_rx_hold = bus.rd && bus.addr == ADDR_RX_HOLD && !bus.divisor_sel;
    wr_tx_hold = bus.wr && bus.addr == ADDR_RX_HOLD && !bus.divisor_sel;
    rd_mask = bus.rd && bus.addr == ADDR_MASK && !bus.divisor_sel;
    wr_mask = bus.wr && bus.addr == ADDR_MASK && !bus.divisor_sel;
    rd_source = bus.rd && bus.addr == ADDR_SOURCE && !bus.enh_bank;
    wr_qc = bus.wr && bus.addr == ADDR_SOURCE && !bus.enh_bank;
    rd_line = bus.rd && bus.addr == ADDR_LINE && !bus.enh_bank;
    rd_modem = bus.rd && bus.addr == ADDR_MODEM;
  end

  // (R9) Upper mask bits count only with enhanced functions on
  assign eff_mask = enh_enable ? mask : (mask & MASK_BASIC);

  // (R24) Trigger decode, one code table for both directions
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_level = TRIG_L0;
      2'h1: trig_level = TRIG_L1;
      2'h2: trig_level = TRIG_L2;
      2'h3: trig_level = TRIG_L3;
    endcase
  endfunction

  // Control register writes
  always_comb begin
    next_mask = mask;
    next_fifo_en = fifo_en;
    next_rx_sel = rx_sel;
    next_tx_sel = tx_sel;
    next_rx_rst = 1'b0;
    next_tx_rst = 1'b0;
    // (R9) Upper bits held back without enhanced enable
    if (wr_mask) begin
      next_mask = enh_enable ? bus.wdata : {mask[7:4], bus.wdata[3:0]};
    end
    // (R21) Other fields only land with the enable bit set
    if (wr_qc) begin
      next_fifo_en = bus.wdata[QC_ENABLE];
      if (bus.wdata[QC_ENABLE]) begin
        // (R22) Receive reset, one cycle pulse
        next_rx_rst = bus.wdata[QC_RX_RESET];
        // (R23) Transmit reset, one cycle pulse
        next_tx_rst = bus.wdata[QC_TX_RESET];
        next_rx_sel = bus.wdata[QC_RX_TRIG_LO +: 2];
        if (enh_enable) begin
          next_tx_sel = bus.wdata[QC_TX_TRIG_LO +: 2];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mask <= MASK_RESET;
      fifo_en <= 1'b0;
      rx_sel <= TRIG_SEL_RESET;
      tx_sel <= TRIG_SEL_RESET;
      rx_rst <= 1'b0;
      tx_rst <= 1'b0;
    end else begin
      mask <= next_mask;
      fifo_en <= next_fifo_en;
      rx_sel <= next_rx_sel;
      tx_sel <= next_tx_sel;
      rx_rst <= next_rx_rst;
      tx_rst <= next_tx_rst;
    end
  end

  // (R1) Level-driven, so it drops as soon as the queue drains below
  always_comb begin
    if (fifo_en) begin
      rx_data_act = rx.level >= trig_level(rx_sel);
      tx_below = tx.level < trig_level(tx_sel);
    end else begin
      rx_data_act = rx.level != 5'h00;
      tx_below = tx.level == 5'h00;
    end
  end

  // (R10) Output pin is ours, no synchroniser needed
  assign rts_rise = flow.rts_n & ~rts_q;

  // Sticky flags: every set term wins over a same-cycle clear
  always_comb begin
    next_tx_below_q = tx_below;
    next_overrun = (overrun && !rd_line) || rx.overrun;
    // (R7) Overrun at arrival, other errors when at read port
    // (R13) Line read drops the interrupt
    next_line_pend = (line_pend && !rd_line) || rx.overrun || rx.err_at_port;
    // (R11) Cleared only by reading receive data
    next_tmo_pend = (tmo_pend && !rd_rx_hold) || tmo_expire;
    // (R12) Cleared by reporting it or by new transmit data
    next_tx_pend = tx_pend && !wr_tx_hold && !(rd_source && src_code == SRC_TX_READY);
    // (R6) Fresh drop below trigger, or enabling while already below it
    if ((tx_below && !tx_below_q) || (wr_mask && bus.wdata[MASK_TX] && !mask[MASK_TX] &&
        tx_below)) begin
      next_tx_pend = 1'b1;
    end
    // (R8) Any modem delta; cleared by modem status read
    next_modem_pend = (modem_pend && !rd_modem) || (flow.modem_delta != 4'h0);
    // (R10) Pin rises only count under automatic flow control
    next_pin_pend = (pin_pend && !rd_modem) || (flow.auto_rts && rts_rise) ||
                    (flow.auto_cts && cts_rise);
    // (R14) Xoff waits for Xon or a source read
    next_xoff_pend = (xoff_pend && !flow.xon && !(rd_source && src_code == SRC_XOFF)) ||
                     flow.xoff;
    // (R14) Special character goes on the next character
    next_spec_pend = (spec_pend && !rx.loaded && !(rd_source && src_code == SRC_XOFF)) ||
                     flow.special;
    // (R15) Wake-up cleared by a source read
    next_wake_pend = (wake_pend && !rd_source) || flow.wake;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      line_pend <= 1'b0;
      overrun <= 1'b0;
      tmo_pend <= 1'b0;
      tx_pend <= 1'b0;
      modem_pend <= 1'b0;
      pin_pend <= 1'b0;
      xoff_pend <= 1'b0;
      spec_pend <= 1'b0;
      wake_pend <= 1'b0;
      tx_below_q <= 1'b0;
      rts_q <= 1'b1;
    end else begin
      line_pend <= next_line_pend;
      overrun <= next_overrun;
      tmo_pend <= next_tmo_pend;
      tx_pend <= next_tx_pend;
      modem_pend <= next_modem_pend;
      pin_pend <= next_pin_pend;
      xoff_pend <= next_xoff_pend;
      spec_pend <= next_spec_pend;
      wake_pend <= next_wake_pend;
      tx_below_q <= next_tx_below_q;
      rts_q <= flow.rts_n;
    end
  end

  // (R16) Priority chain; only the winner is shown, the rest stay queued
  // (R17) Codes in priority order one to seven
  // (R20) Bits five and four reachable only through enhanced masks
  // (R5) Receive sources gated by mask bit zero
  always_comb begin
    if (eff_mask[MASK_LINE] && line_pend) begin
      src_code = SRC_LINE;
    end else if (eff_mask[MASK_RX] && tmo_pend) begin
      src_code = SRC_TIMEOUT;
    end else if (eff_mask[MASK_RX] && rx_data_act) begin
      src_code = SRC_RX_DATA;
    end else if (eff_mask[MASK_TX] && tx_pend) begin
      src_code = SRC_TX_READY;
    end else if (eff_mask[MASK_MODEM] && modem_pend) begin
      src_code = SRC_MODEM;
    end else if (eff_mask[MASK_XOFF] && (xoff_pend || spec_pend)) begin
      src_code = SRC_XOFF;
    end else if ((eff_mask[MASK_RTS] || eff_mask[MASK_CTS]) && pin_pend) begin
      src_code = SRC_PIN;
    end else begin
      // (R18) Idle and wake-up both read with bit zero set
      src_code = SRC_NONE;
    end
    // (R19) Top two bits mirror the queue enable
    source_val = {fifo_en, fifo_en, src_code};
    // (R4) Line status layout; (R2) ready follows queue occupancy
    line_val = {rx.err_in_fifo, (tx.level == 5'h00) && tx.shift_empty,
                tx.level == 5'h00, rx.top_err, overrun, rx.level != 5'h00};
  end

  // Read data registered; other addresses return zero from this block
  always_comb begin
    next_rdata = rdata;
    if (rd_mask) begin
      next_rdata = mask;
    end else if (rd_source) begin
      next_rdata = source_val;
    end else if (rd_line) begin
      next_rdata = line_val;
    end else if (bus.rd) begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata <= {2'h0, SRC_NONE};
    end else begin
      rdata <= next_rdata;
    end
  end

  // (R25) Output follows any enabled pending source
  // (R3) With every mask bit clear nothing reaches the output
  assign irq = (src_code != SRC_NONE) || (wake_pend && eff_mask[MASK_SLEEP]);
  assign rd_data = rdata;
  assign fifo_enable = fifo_en;
  assign rx_fifo_reset = rx_rst;
  assign tx_fifo_reset = tx_rst;
  assign rx_trigger = trig_level(rx_sel);
  assign tx_trigger = trig_level(tx_sel);
  assign sleep_enable = eff_mask[MASK_SLEEP];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  rx_data_src_a: assert property ( // R1
    (eff_mask[MASK_RX] && fifo_en && rx_data_act && !line_pend && !tmo_pend) |->
      src_code == SRC_RX_DATA && irq)
    else $error("rx data level not reported");
  qc_reset_pulse_a: assert property ( // R22
    (wr_qc && bus.wdata[QC_ENABLE] && bus.wdata[QC_RX_RESET]) |=> rx_fifo_reset ##1 !rx_fifo_reset)
    else $error("rx queue reset not a single pulse");
  qc_gate_a: assert property ( // R21
    (wr_qc && !bus.wdata[QC_ENABLE]) |=> !fifo_enable && !rx_fifo_reset && $stable(rx_trigger))
    else $error("control bits landed without enable");
  tx_trig_gate_a: assert property ( // R24
    (wr_qc && !enh_enable) |=> $stable(tx_trigger))
    else $error("tx trigger changed without enhanced enable");
  source_top_a: assert property ( // R19
    rd_source |=> rd_data[7:6] == {2{$past(fifo_en)}})
    else $error("queue enable bits wrong on source read");
  line_clear_a: assert property ( // R13
    (rd_line && !rx.overrun && !rx.err_at_port) |=> !line_pend)
    else $error("line read did not clear line interrupt");
  timeout_hold_a: assert property ( // R11
    (tmo_pend && !rd_rx_hold) |=> tmo_pend)
    else $error("timeout cleared without data read");
  xoff_clear_a: assert property ( // R14
    (flow.xon && !flow.xoff) |=> !xoff_pend)
    else $error("xoff survived xon");
  tx_clear_a: assert property ( // R12
    (wr_tx_hold && !(tx_below && !tx_below_q)) |=> !tx_pend)
    else $error("tx ready survived holding write");
  modem_raise_a: assert property ( // R8
    (flow.modem_delta != 4'h0 && eff_mask[MASK_MODEM] && !wr_mask) |=> irq)
    else $error("modem delta did not raise interrupt");
  upper_mask_a: assert property ( // R9
    (wr_mask && !enh_enable) |=> mask[7:4] == $past(mask[7:4]))
    else $error("upper mask bits written without enhanced enable");
  idle_level_a: assert property ( // R18
    (src_code == SRC_NONE && rd_source) |=> rd_data[0])
    else $error("idle source read bit zero low");

  rx_trig_c: cover property (wr_qc ##1 rx_data_act && irq);
  tmo_c: cover property (tmo_expire ##[1:20] rd_rx_hold);
  pin_c: cover property (cts_rise && flow.auto_cts);
  wake_c: cover property (flow.wake ##[1:10] rd_source);
endmodule // uqc_irq_ctrl

// >>> include/uqc_pkg.sv
package uqc_pkg;
  // Register addresses on the three-bit parallel bus
  localparam logic [2:0] ADDR_RX_HOLD = 3'h0;
  localparam logic [2:0] ADDR_MASK = 3'h1;
  localparam logic [2:0] ADDR_SOURCE = 3'h2;
  localparam logic [2:0] ADDR_LINE = 3'h5;
  localparam logic [2:0] ADDR_MODEM = 3'h6;
  // Reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [1:0] TRIG_SEL_RESET = 2'h0;
  // Mask register bit positions
  localparam int MASK_RX = 0;
  localparam int MASK_TX = 1;
  localparam int MASK_LINE = 2;
  localparam int MASK_MODEM = 3;
  localparam int MASK_SLEEP = 4;
  localparam int MASK_XOFF = 5;
  localparam int MASK_RTS = 6;
  localparam int MASK_CTS = 7;
  localparam logic [7:0] MASK_BASIC = 8'h0f;
  // Queue control register bit positions
  localparam int QC_ENABLE = 0;
  localparam int QC_RX_RESET = 1;
  localparam int QC_TX_RESET = 2;
  localparam int QC_TX_TRIG_LO = 4;
  localparam int QC_RX_TRIG_LO = 6;
  // Source codes in bits 5..0, priority 1 first
  localparam logic [5:0] SRC_LINE = 6'h06;
  localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
  localparam logic [5:0] SRC_RX_DATA = 6'h04;
  localparam logic [5:0] SRC_TX_READY = 6'h02;
  localparam logic [5:0] SRC_MODEM = 6'h00;
  localparam logic [5:0] SRC_XOFF = 6'h10;
  localparam logic [5:0] SRC_PIN = 6'h20;
  localparam logic [5:0] SRC_NONE = 6'h01;
  // Trigger levels selected by codes 00..11
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0e;
  // Receive time-out span: four characters plus twelve bits
  localparam logic [6:0] TIMEOUT_CHARS = 7'h04;
  localparam logic [6:0] TIMEOUT_EXTRA_BITS = 7'h0c;

  // Host bus access, strobes are one-cycle pulses
  typedef struct packed {
    logic [2:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic divisor_sel;
    logic enh_bank;
  } uqc_bus_s;

  // Receive side events and state
  typedef struct packed {
    logic [4:0] level;
    logic loaded;
    logic overrun;
    logic err_at_port;
    logic [2:0] top_err;
    logic err_in_fifo;
  } uqc_rx_s;

  // Transmit side state
  typedef struct packed {
    logic [4:0] level;
    logic shift_empty;
  } uqc_tx_s;

  // Flow control, modem and sleep events
  typedef struct packed {
    logic xoff;
    logic xon;
    logic special;
    logic wake;
    logic [3:0] modem_delta;
    logic auto_rts;
    logic auto_cts;
    logic rts_n;
  } uqc_flow_s;
endpackage

// >>> core/uqc_pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser with a rising edge pulse
module uqc_pin_sync
  import uqc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // Edge detector reads only the second stage
  always_comb begin
    next_meta = pin;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level = sync;
  assign rise = sync & ~prev;
endmodule // uqc_pin_sync

// >>> core/uqc_rx_timeout.sv
`timescale 1ns/1ps
// Receive idle timer counted in bit ticks
module uqc_rx_timeout
  import uqc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic bit_tick,
  input wire logic restart,
  input wire logic armed,
  input wire logic [3:0] char_bits,
  output logic expire
);
  logic [6:0] count;
  logic done;
  logic [6:0] next_count;
  logic next_done;
  logic [6:0] span;

  // Fires once per idle stretch; data arrival or a read rearms it
  always_comb begin
    span = TIMEOUT_CHARS * {3'h0, char_bits} + TIMEOUT_EXTRA_BITS;
    next_count = count;
    next_done = done;
    expire = 1'b0;
    if (restart || !armed) begin
      next_count = '0;
      next_done = 1'b0;
    end else if (bit_tick && !done) begin
      next_count = count + 7'h01;
      if (next_count >= span) begin
        next_done = 1'b1;
        expire = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end
endmodule // uqc_rx_timeout

// >>> sim/uqc_host_model.sv
`timescale 1ns/1ps
// Host processor on the parallel register bus, one access at a time
module uqc_host_model
  import uqc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] rd_data,
  output uqc_bus_s bus
);
  initial bus = '0;

  // Write strobe held for exactly one rising edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    bus.addr = a;
    bus.wdata = d;
    bus.wr = 1'b1;
    @(negedge sys_clk);
    bus.wr = 1'b0;
    bus.wdata = ~d; // Stale data must not look valid
  endtask

  // Read data is registered, so it is taken half a cycle after the edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    bus.addr = a;
    bus.rd = 1'b1;
    @(negedge sys_clk);
    bus.rd = 1'b0;
    d = rd_data;
  endtask

  task automatic qc_wr(input logic [7:0] d);
    wr(ADDR_SOURCE, d | 8'h01);
  endtask

  task automatic poll(input logic [2:0] a, output logic [7:0] d);
    rd(a, d);
  endtask

  // Bank selects follow the line format state, changed between accesses
  task automatic bank(input logic dsel, input logic ebank);
    @(negedge sys_clk);
    bus.divisor_sel = dsel;
    bus.enh_bank = ebank;
  endtask
endmodule // uqc_host_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import uqc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic enh = 1'b0;
  logic cts_n = 1'b0;
  logic tick = 1'b0;
  logic [3:0] cbits = 4'ha;
  int span_t;
  logic irq, fe, rxr, txr, slp;
  logic [4:0] rxt, txt;
  logic [7:0] rdd, got;
  uqc_bus_s bus;
  uqc_rx_s rx = '0;
  uqc_tx_s tx = '{level: 5'h00, shift_empty: 1'b1};
  uqc_flow_s flow = '0;
  logic [31:0] seed = 32'hd39f_8a41;
  int n_mismatch = 0;
  int tests_run = 0;
  // Model state: pending sources by priority, wake flag, queue enable
  int pend[7];
  int wake_p;
  int fifo_on;
  localparam logic [5:0] CODE [7] = '{SRC_LINE, SRC_TIMEOUT, SRC_RX_DATA, SRC_TX_READY,
    SRC_MODEM, SRC_XOFF, SRC_PIN};
  localparam logic [4:0] LVL [4] = '{TRIG_L0, TRIG_L1, TRIG_L2, TRIG_L3};

  always #10 sys_clk = ~sys_clk;

  uqc_host_model uqc_host_model_inst (.sys_clk(sys_clk), .rd_data(rdd), .bus(bus));
  uqc_irq_ctrl uqc_irq_ctrl_inst (.sys_clk(sys_clk), .reset(reset), .bus(bus), .rd_data(rdd),
    .enh_enable(enh), .rx(rx), .tx(tx), .flow(flow), .cts_n_pin(cts_n), .bit_tick(tick),
    .char_bits(cbits), .irq(irq), .fifo_enable(fe), .rx_fifo_reset(rxr),
    .tx_fifo_reset(txr), .rx_trigger(rxt), .tx_trigger(txt), .sleep_enable(slp));

  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Highest pending source wins, lower ones stay queued
  function automatic logic [7:0] model_src();
    logic [1:0] f;
    f = (fifo_on != 0) ? 2'b11 : 2'b00;
    for (int i = 0; i < 7; i++) begin
      if (pend[i] != 0) return {f, CODE[i]};
    end
    return {f, SRC_NONE};
  endfunction

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic w(input logic [2:0] a, input logic [7:0] d);
    uqc_host_model_inst.wr(a, d);
  endtask

  task automatic r(input logic [2:0] a);
    uqc_host_model_inst.poll(a, got);
  endtask

  // Read the source register and retire what that read clears
  task automatic isr_chk();
    logic [7:0] e;
    e = model_src();
    r(ADDR_SOURCE);
    chk(got, e);
    if (e[5:0] == SRC_TX_READY) pend[3] = 0;
    if (e[5:0] == SRC_XOFF) pend[5] = 0;
    wake_p = 0;
    chk({7'h00, irq}, {7'h00, (model_src() & 8'h01) == 8'h00});
  endtask

  // One-cycle event pulse from the receive or flow side
  task automatic ev(input int k);
    step(1);
    case (k)
      0: flow.xoff = 1'b1;
      1: flow.xon = 1'b1;
      2: flow.special = 1'b1;
      3: flow.wake = 1'b1;
      4: flow.modem_delta = seed[3:0] | 4'h1;
      6: rx.loaded = 1'b1;
      default: rx.overrun = 1'b1;
    endcase
    step(1);
    flow.xoff = 1'b0;
    flow.xon = 1'b0;
    flow.special = 1'b0;
    flow.wake = 1'b0;
    flow.modem_delta = 4'h0;
    rx.overrun = 1'b0;
    rx.loaded = 1'b0;
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    step(6000);
    n_mismatch++;
    close_out();
  end

  initial begin
    pend = '{default: 0};
    wake_p = 0;
    fifo_on = 0;
    step(5);
    reset = 1'b0;
    // Reset state and refused writes
    isr_chk();
    chk({3'h0, rxt}, {3'h0, TRIG_L0});
    w(ADDR_SOURCE, 8'hc6);
    chk({6'h00, fe, rxr}, 8'h00);
    w(ADDR_MASK, 8'hff);
    r(ADDR_MASK);
    chk(got, 8'h0f);
    uqc_host_model_inst.qc_wr(8'h30);
    chk({3'h0, txt}, {3'h0, TRIG_L0});
    // Trigger select table in both directions
    enh = 1'b1;
    for (int c = 0; c < 4; c++) begin
      uqc_host_model_inst.qc_wr({c[1:0], c[1:0], 4'h0});
      chk({rxt, 3'h0}, {LVL[c], 3'h0});
      chk({txt, 3'h0}, {LVL[c], 3'h0});
    end
    fifo_on = 1;
    uqc_host_model_inst.qc_wr(8'h46);
    chk({6'h00, rxr, txr}, 8'h03);
    step(1);
    chk({6'h00, rxr, txr}, 8'h00);
    // Receive data level against trigger 4, line status above it
    w(ADDR_MASK, 8'h05);
    seed = lfsr(seed);
    rx.level = 5'd4 + 5'(seed[7:0] % 13);
    pend[2] = 1;
    isr_chk();
    rx.err_in_fifo = 1'b1;
    ev(5);
    pend[0] = 1;
    isr_chk();
    r(ADDR_LINE);
    chk(got, 8'he3);
    pend[0] = 0;
    isr_chk();
    r(ADDR_LINE);
    chk(got, 8'he1);
    rx.level = 5'd3;
    pend[2] = 0;
    isr_chk();
    rx.level = 5'd0;
    rx.err_in_fifo = 1'b0;
    r(ADDR_LINE);
    chk(got, 8'h60);
    // Receive time-out with trigger 14, one byte waiting, two frame sizes
    uqc_host_model_inst.qc_wr(8'hc0);
    w(ADDR_MASK, 8'h01);
    rx.level = 5'd1;
    for (int b = 7; b < 11; b += 3) begin
      cbits = 4'(b);
      span_t = TIMEOUT_CHARS * b + TIMEOUT_EXTRA_BITS;
      for (int i = 0; i < span_t; i++) begin
        if (i == span_t - 1) isr_chk();
        tick = 1'b1;
        step(1);
        tick = 1'b0;
        step(1);
      end
      pend[1] = 1;
      isr_chk();
      r(ADDR_RX_HOLD);
      pend[1] = 0;
      isr_chk();
    end
    rx.level = 5'd0;
    // Transmit ready: enable while empty, then a fresh drop
    w(ADDR_MASK, 8'h02);
    pend[3] = 1;
    isr_chk();
    isr_chk();
    tx.level = 5'd5;
    step(2);
    tx.level = 5'd0;
    pend[3] = 1;
    step(2);
    chk({7'h00, irq}, {7'h00, pend[3] != 0});
    w(ADDR_RX_HOLD, 8'h55);
    pend[3] = 0;
    isr_chk();
    // Modem delta survives source reads, cleared by modem read
    w(ADDR_MASK, 8'h08);
    seed = lfsr(seed);
    ev(4);
    pend[4] = 1;
    isr_chk();
    isr_chk();
    r(ADDR_MODEM);
    pend[4] = 0;
    isr_chk();
    // Xoff and special character clearing
    w(ADDR_MASK, 8'h20);
    for (int k = 0; k < 4; k++) begin
      ev(k[0] ? 2 : 0);
      pend[5] = 1;
      if (k >= 2) begin
        ev(k == 2 ? 1 : 6);
        pend[5] = 0;
      end
      isr_chk();
    end
    // Flow pin rises, first without enhanced enable
    enh = 1'b0;
    w(ADDR_MASK, 8'hc0);
    flow.auto_cts = 1'b1;
    flow.auto_rts = 1'b1;
    for (int p = 0; p < 3; p++) begin
      if (p == 1) enh = 1'b1;
      if (p == 1) w(ADDR_MASK, 8'hc0);
      cts_n = (p == 2);
      flow.rts_n = 1'b0;
      step(4);
      cts_n = 1'b1;
      flow.rts_n = (p == 2);
      step(5);
      pend[6] = (p != 0);
      isr_chk();
      r(ADDR_MODEM);
      pend[6] = 0;
    end
    // Wake-up reports no code but drives the output
    w(ADDR_MASK, 8'h10);
    chk({7'h00, slp}, 8'h01);
    ev(3);
    wake_p = 1;
    chk({7'h00, irq}, {7'h00, wake_p != 0});
    isr_chk();
    // Polled mode: all basic masks off
    w(ADDR_MASK, 8'h00);
    rx.level = 5'd16;
    ev(5);
    chk({7'h00, irq}, 8'h00);
    r(ADDR_LINE);
    chk(got, 8'h63);
    isr_chk();
    // Bank selects hide the mask, source and control addresses
    w(ADDR_MASK, 8'h08);
    uqc_host_model_inst.bank(1'b1, 1'b1);
    w(ADDR_MASK, 8'h0f);
    uqc_host_model_inst.qc_wr(8'h00);
    chk({3'h0, rxt}, {3'h0, TRIG_L3});
    r(ADDR_MASK);
    chk(got, 8'h00);
    r(ADDR_SOURCE);
    chk(got, 8'h00);
    uqc_host_model_inst.bank(1'b0, 1'b0);
    r(ADDR_MASK);
    chk(got, 8'h08);
    isr_chk();
    close_out();
  end
endmodule // tb_top
